// ==== bench/interlaced_to_progressive_video_port_test.sv ====
// bench: register tasks, source-model lines, output capture and compare
// assumes: ipv_video_port in its default build, one 200 MHz clock
`timescale 1ns/100ps
`default_nettype none
module interlaced_to_progressive_video_port_test;
  import ipv_pkg::*;
  logic aclk = 0, vrst_n = 0, crst_n = 0, mrst_n = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wr_rdy, bv, arr, rv, itr, ov, ou, ol, hb, vb, iv, iu, il, ia, ordy;
  logic [1:0] bresp, rresp;
  logic [23:0] id, od;
  logic [25:0] q[$];
  int bad_count = 0, checks = 0, nv = 0, nh = 0;
  initial forever #2.5 aclk = ~aclk;
  ipv_video_port dut (.aclk(aclk), .aresetn(vrst_n), .s_axi_aresetn(crst_n),
    .m_axi_aresetn(mrst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axis_tdata(id), .s_axis_tvalid(iv),
    .s_axis_tready(itr), .s_axis_tuser(iu), .s_axis_tlast(il), .s_vid_active(ia),
    .m_axis_tdata(od), .m_axis_tvalid(ov), .m_axis_tready(ordy), .m_axis_tuser(ou),
    .m_axis_tlast(ol), .m_hblank(hb), .m_vblank(vb));
  ipv_src_model src (.aclk(aclk), .tdata(id), .tvalid(iv), .tuser(iu), .tlast(il),
    .active(ia), .ordy(ordy));
  // capture accepted beats and count strobe cycles
  always @(posedge aclk) begin
    if (ov === 1'b1 && ordy === 1'b1) q.push_back({ou, ol, od});
    if (vb === 1'b1) nv++;
    if (hb === 1'b1) nh++;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awv, wv, br} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    chk("bresp", bresp, er);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    {arv, rr} <= 2'b11;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
  endtask : rd
  // one input line; enabled output is the line twice with strobes around it
  task automatic line_out(input int n, input bit sof, mask, en, input logic [23:0] b);
    int t;
    logic [23:0] p;
    q.delete();
    {nv, nh, t} = '0;
    src.send_line(n, sof, b);
    while (q.size() < 2 * n && t < 500) begin
      @(posedge aclk);
      t++;
    end
    repeat (40) @(posedge aclk);
    chk("beats", q.size(), en ? 2 * n : 0);
    for (int i = 0; i < (en ? 2 * n : 0); i++) begin
      p = b + 24'(i % n);
      if (mask) p[23:16] = 8'h00;
      chk("pixel", q[i], {sof && i == 0, i % n == n - 1, p});
    end
    chk("vblank", nv, (en && sof) ? 5 : 0);
    chk("hblank", nh, en ? 6 : 0);
  endtask : line_out
  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge aclk);
    {vrst_n, crst_n, mrst_n} <= 3'b111;
    rd(OFS_CTRL, 32'h00000002, RESP_OKAY);
    chk("tready", itr, 32'h00000001);
    rd(OFS_HBLANK, 32'h00000010, RESP_OKAY);
    rd(OFS_VBLANK, 32'h00000040, RESP_OKAY);
    rd(OFS_CAPS, 32'h00000008, RESP_OKAY);
    rd(8'h18, 32'h00000000, RESP_SLVERR);
    line_out(4, 1'b1, 1'b0, 1'b0, 24'h102030);
    wr(OFS_HBLANK, 32'h00000003, RESP_OKAY);
    wr(OFS_VBLANK, 32'h00000005, RESP_OKAY);
    wr(OFS_CAPS, 32'h00000000, RESP_SLVERR);
    rd(OFS_CAPS, 32'h00000008, RESP_OKAY);
    src.stall <= 1'b1;
    for (int f = 0; f < 3; f++) begin
      wr(OFS_CTRL, 32'(1 + 2 * f), RESP_OKAY);
      line_out(3, f == 0, f != 0, 1'b1, 24'hA0B0C0 + 24'(f));
      rd(OFS_LINE_LEN, 32'h00000003, RESP_OKAY);
    end
    rd(OFS_STATUS, 32'h00000000, RESP_OKAY);
    // third line closes while the second still waits behind a busy sequencer
    src.send_line(3, 1'b1, 24'h000011);
    repeat (2) src.send_line(3, 1'b0, 24'h000022);
    repeat (100) @(posedge aclk);
    rd(OFS_STATUS, 32'h00000002, RESP_OKAY);
    wr(OFS_STATUS, 32'h00000002, RESP_OKAY);
    rd(OFS_STATUS, 32'h00000000, RESP_OKAY);
    // video reset while the output is in vblank leaves registers untouched
    src.send_line(3, 1'b1, 24'h000055);
    repeat (2) @(posedge aclk);
    vrst_n <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("idle", {ov, hb, vb}, 32'h00000000);
    vrst_n <= 1'b1;
    rd(OFS_CTRL, 32'h00000005, RESP_OKAY);
    crst_n <= 1'b0;
    repeat (2) @(posedge aclk);
    crst_n <= 1'b1;
    rd(OFS_CTRL, 32'h00000002, RESP_OKAY);
    tally_and_finish();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    tally_and_finish();
  end
endmodule : interlaced_to_progressive_video_port_test
`default_nettype wire

// ==== bench/ipv_checker.sv ====
// checker: stream and register-bus relations of the video port
// assumes: bound into ipv_video_port, everything on aclk
`timescale 1ns/100ps
`default_nettype none
module ipv_checker #(
  parameter int COMP_W = 8 // component bits
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // video reset
  input wire logic s_axi_aresetn, // control reset
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axis_tready, // in ready
  input wire logic [3*COMP_W-1:0] m_axis_tdata, // out pixel
  input wire logic m_axis_tvalid, // out valid
  input wire logic m_axis_tready, // out ready
  input wire logic m_axis_tuser, // out sof
  input wire logic m_hblank, // hblank
  input wire logic m_vblank // vblank
);
  // ==========================================================
  // video side
  property p_rdy;
    @(posedge aclk) disable iff (!aresetn) s_axis_tready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("input ready low");
  // no disable here: the reset itself is the cause
  property p_rst;
    @(posedge aclk) !aresetn |=> !m_axis_tvalid && !m_axis_tuser && !m_hblank && !m_vblank;
  endproperty
  a_rst: assert property (p_rst) else $error("output active after reset");
  property p_hold;
    @(posedge aclk) disable iff (!aresetn) m_axis_tvalid && !m_axis_tready
      |=> m_axis_tvalid && $stable(m_axis_tdata) && $stable(m_axis_tuser);
  endproperty
  a_hold: assert property (p_hold) else $error("output beat changed in stall");
  property p_sof;
    @(posedge aclk) disable iff (!aresetn) m_axis_tuser |-> m_axis_tvalid;
  endproperty
  a_sof: assert property (p_sof) else $error("frame start without a beat");
  property p_strb;
    @(posedge aclk) disable iff (!aresetn) m_vblank |-> !m_hblank && !m_axis_tvalid;
  endproperty
  a_strb: assert property (p_strb) else $error("pixel inside vblank");
  // ==========================================================
  // register bus
  property p_ar;
    @(posedge aclk) disable iff (!s_axi_aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_ar: assert property (p_ar) else $error("read answer late");
  property p_ar_blk;
    @(posedge aclk) disable iff (!s_axi_aresetn) s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_blk: assert property (p_ar_blk) else $error("second read taken");
  property p_b_once;
    @(posedge aclk) disable iff (!s_axi_aresetn) s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("write answer repeated");
endmodule : ipv_checker
bind ipv_video_port ipv_checker #(.COMP_W(COMP_W)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_aresetn(s_axi_aresetn), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axis_tready(s_axis_tready), .m_axis_tdata(m_axis_tdata), .m_axis_tvalid(m_axis_tvalid),
  .m_axis_tready(m_axis_tready), .m_axis_tuser(m_axis_tuser), .m_hblank(m_hblank),
  .m_vblank(m_vblank));
`default_nettype wire

// ==== bench/ipv_src_model.sv ====
// upstream pixel source and downstream ready of the video port
// assumes: tasks are entered just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module ipv_src_model (
  input wire logic aclk, // clock
  output logic [23:0] tdata, // pixel
  output logic tvalid, // valid
  output logic tuser, // first pixel of frame
  output logic tlast, // end of line
  output logic active, // active video
  output logic ordy // downstream ready
);
  logic stall = 1'b0;
  initial begin
    {tdata, tvalid, tuser, tlast, active} = '0;
    ordy = 1'b1;
  end
  // with stall set, downstream ready toggles every cycle; no extra buffering is offered
  always @(posedge aclk) ordy <= stall ? ~ordy : 1'b1;
  // one pixel every other cycle; idle cycles scramble the data lines
  task automatic send_line(input int n, input bit sof, input logic [23:0] b);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      {tvalid, active, tuser, tlast} <= {2'b11, sof && i == 0, i == n - 1};
      tdata <= b + 24'(i);
      @(posedge aclk);
      {tvalid, tuser, tlast} <= 3'b000;
      tdata <= ~tdata;
    end
    // blanking sample with valid and a stray frame flag, to be dropped
    @(posedge aclk);
    {tvalid, active, tuser} <= 3'b101;
    @(posedge aclk);
    {tvalid, tuser} <= 2'b00;
    tdata <= ~tdata;
  endtask : send_line
endmodule : ipv_src_model
`default_nettype wire

// ==== logic/ipv_line_ram.sv ====
// ping-pong line store for the video port
// assumes: write and read share aclk; read data registered
`timescale 1ns/100ps
`default_nettype none
module ipv_line_ram #(
  parameter int DATA_W = 24,
  parameter int ADDR_W = 12
) (
  input wire logic aclk, // clock
  input wire logic m_axi_aresetn, // memory-side reset, active low
  input wire logic we, // write enable
  input wire logic [ADDR_W-1:0] waddr, // write address
  input wire logic [DATA_W-1:0] wdata, // write data
  input wire logic re, // read enable
  input wire logic [ADDR_W-1:0] raddr, // read address
  output logic [DATA_W-1:0] rdata // read data, registered
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // ==========================================================
  // storage write, no reset so it maps to block ram
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // read register holds its value while re is low
  always_ff @(posedge aclk) begin
    if (!m_axi_aresetn) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule : ipv_line_ram
`default_nettype wire

// ==== logic/ipv_pkg.sv ====
// package for the interlaced-to-progressive video port
// assumes: one clock aclk (200 MHz), synchronous active-low resets
package ipv_pkg;
  // ==========================================================
  // register bus
  localparam int AXIL_AW = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LINE_LEN = 8'h08;
  localparam logic [7:0] OFS_CAPS = 8'h0C;
  localparam logic [7:0] OFS_HBLANK = 8'h10;
  localparam logic [7:0] OFS_VBLANK = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FMT_LSB = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int CAP_DIAG_BIT = 0;
  localparam int CAP_MOTION_BIT = 1;
  localparam int CAP_CADENCE_BIT = 2;
  localparam int CAP_DYNFMT_BIT = 3;
  localparam int BLANK_W = 16;
  // ==========================================================
  // reset values
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [BLANK_W-1:0] HBLANK_RST = 16'h0010;
  localparam logic [BLANK_W-1:0] VBLANK_RST = 16'h0040;
  // ==========================================================
  // chroma arrangements
  typedef enum logic [1:0] {
    IPV_FMT_444 = 2'b00,
    IPV_FMT_422 = 2'b01,
    IPV_FMT_420 = 2'b10
  } ipv_fmt_e;
  // output sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_VBLANK = 3'b001,
    ST_LINE_A = 3'b010,
    ST_HBL_A = 3'b011,
    ST_LINE_B = 3'b100,
    ST_HBL_B = 3'b101
  } ipv_state_e;
  // ==========================================================
  // stream sideband carried with each pixel
  typedef struct packed {
    logic sof;
    logic eol;
  } ipv_sb_s;
endpackage : ipv_pkg

// ==== logic/ipv_video_port.sv ====
// video port of an interlaced-to-progressive converter: line doubler
// assumes: upstream paces valid to half the clock, downstream mostly ready
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ipv_video_port #(
  parameter int MAX_W = 2048, // longest active line, 128..2048
  parameter int COMP_W = 8, // bits per component, 8/10/12
  parameter bit DYN_FMT = 1'b1, // chroma arrangement set by software
  parameter ipv_pkg::ipv_fmt_e STATIC_FMT = ipv_pkg::IPV_FMT_422,
  parameter bit INCL_DIAG = 1'b0, // diagonal engine built in
  parameter bit INCL_MOTION = 1'b0, // motion engine built in
  parameter bit INCL_CADENCE = 1'b0 // cadence controller built in
) (
  input wire logic aclk, // single clock for all domains
  input wire logic aresetn, // video reset, active low
  input wire logic s_axi_aresetn, // control reset, active low
  input wire logic m_axi_aresetn, // memory reset, active low
  input wire logic [ipv_pkg::AXIL_AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ipv_pkg::AXIL_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [3*COMP_W-1:0] s_axis_tdata, // input pixel
  input wire logic s_axis_tvalid, // input valid
  output logic s_axis_tready, // input ready, always high
  input wire logic s_axis_tuser, // first pixel of frame
  input wire logic s_axis_tlast, // last pixel of line
  input wire logic s_vid_active, // sample lies in active video
  output logic [3*COMP_W-1:0] m_axis_tdata, // output pixel
  output logic m_axis_tvalid, // output valid
  input wire logic m_axis_tready, // output ready
  output logic m_axis_tuser, // first output pixel of frame
  output logic m_axis_tlast, // last pixel of output line
  output logic m_hblank, // generated horizontal blanking
  output logic m_vblank // generated vertical blanking
);
  import ipv_pkg::*;

  // ==========================================================
  // build-time shaping
  localparam int LW = (MAX_W < 128) ? 128 : ((MAX_W > 2048) ? 2048 : MAX_W);
  localparam int X_W = $clog2(LW);
  localparam int L_W = X_W + 1;
  localparam int DATA_W = 3 * COMP_W;
  localparam logic [X_W-1:0] X_LAST = X_W'(LW - 1);
  localparam logic [BLANK_W-1:0] BLANK_ONE = 16'h0001;

  // keeps only the components that the arrangement carries
  function automatic logic [DATA_W-1:0] fmt_mask(input logic [1:0] fmt,
                                                 input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] m;
    m = d;
    if (fmt != IPV_FMT_444) begin
      m[DATA_W-1 -: COMP_W] = '0;
    end
    return m;
  endfunction : fmt_mask

  // byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // ==========================================================
  // control registers
  logic ctrl_en_reg;
  logic [1:0] fmt_reg;
  logic [BLANK_W-1:0] hblank_reg;
  logic [BLANK_W-1:0] vblank_reg;
  logic overrun_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [AXIL_AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic do_wr;
  logic do_rd;
  logic [31:0] wr_val;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // video state
  ipv_state_e state_reg;
  ipv_state_e state_next;
  logic [X_W-1:0] wr_x_reg;
  logic wr_bank_reg;
  logic line_sof_reg;
  logic pend_vld_reg;
  logic pend_bank_reg;
  logic pend_sof_reg;
  logic [L_W-1:0] pend_len_reg;
  logic rd_bank_reg;
  logic rd_sof_reg;
  logic [L_W-1:0] rd_len_reg;
  logic [X_W-1:0] rd_x_reg;
  logic [BLANK_W-1:0] blank_cnt_reg;
  logic out_vld_reg;
  ipv_sb_s out_sb_reg;
  logic hblank_out_reg;
  logic vblank_out_reg;
  logic accept;
  logic [X_W-1:0] wx;
  logic line_done;
  logic take;
  logic issue;
  logic last_px;
  logic blank_end;
  logic [BLANK_W-1:0] blank_len;
  logic [DATA_W-1:0] ram_rdata;

  // ==========================================================
  // register bus: a held write part blocks new reads; a write still goes ahead while a read answer waits
  assign s_axi_awready = !aw_hold_reg;
  assign s_axi_wready = !w_hold_reg;
  assign do_wr = aw_hold_reg && w_hold_reg && !bvalid_reg;
  // a read waits while any part of a write is held
  assign s_axi_arready = !rvalid_reg && !aw_hold_reg && !w_hold_reg;
  assign do_rd = s_axi_arvalid && s_axi_arready;
  assign wr_hit = (aw_addr_reg == OFS_CTRL) || (aw_addr_reg == OFS_STATUS) ||
                  (aw_addr_reg == OFS_HBLANK) || (aw_addr_reg == OFS_VBLANK);
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // address and data captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!s_axi_aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else begin
      if (s_axi_awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_wr) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // write response; unmapped or read-only offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!s_axi_aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // software-written settings
  always_ff @(posedge aclk) begin
    if (!s_axi_aresetn) begin
      ctrl_en_reg <= CTRL_EN_RST;
      fmt_reg <= STATIC_FMT;
      hblank_reg <= HBLANK_RST;
      vblank_reg <= VBLANK_RST;
    end else if (do_wr) begin
      if (aw_addr_reg == OFS_CTRL) begin
        ctrl_en_reg <= wr_val[CTRL_EN_BIT];
        // the reserved code is ignored; fixed builds never change
        if (DYN_FMT && (wr_val[CTRL_FMT_LSB +: 2] != 2'h3)) begin
          fmt_reg <= wr_val[CTRL_FMT_LSB +: 2];
        end
      end else if (aw_addr_reg == OFS_HBLANK) begin
        hblank_reg <= wr_val[BLANK_W-1:0];
      end else if (aw_addr_reg == OFS_VBLANK) begin
        vblank_reg <= wr_val[BLANK_W-1:0];
      end
    end
  end

  // merged word for the addressed register
  always_comb begin
    wr_val = '0;
    if (aw_addr_reg == OFS_CTRL) begin
      wr_val = {29'h0, fmt_reg, ctrl_en_reg};
    end else if (aw_addr_reg == OFS_HBLANK) begin
      wr_val = {16'h0, hblank_reg};
    end else if (aw_addr_reg == OFS_VBLANK) begin
      wr_val = {16'h0, vblank_reg};
    end
    wr_val = wmerge(wr_val, w_data_reg, w_strb_reg);
  end

  // overrun is sticky, write one to clear; a new overrun wins
  always_ff @(posedge aclk) begin
    if (!s_axi_aresetn) begin
      overrun_reg <= 1'b0;
    end else if (line_done && pend_vld_reg && !take) begin
      overrun_reg <= 1'b1;
    end else if (do_wr && (aw_addr_reg == OFS_STATUS) && w_strb_reg[0] &&
                 w_data_reg[STAT_OVR_BIT]) begin
      overrun_reg <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    if (s_axi_araddr == OFS_CTRL) begin
      rd_word = {29'h0, fmt_reg, ctrl_en_reg};
    end else if (s_axi_araddr == OFS_STATUS) begin
      rd_word = {30'h0, overrun_reg, (state_reg != ST_IDLE)};
    end else if (s_axi_araddr == OFS_LINE_LEN) begin
      rd_word = 32'(rd_len_reg);
    end else if (s_axi_araddr == OFS_CAPS) begin
      rd_word = {28'h0, DYN_FMT, INCL_CADENCE, INCL_MOTION, INCL_DIAG};
    end else if (s_axi_araddr == OFS_HBLANK) begin
      rd_word = {16'h0, hblank_reg};
    end else if (s_axi_araddr == OFS_VBLANK) begin
      rd_word = {16'h0, vblank_reg};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!s_axi_aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (do_rd) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // input side: keep active pixels into the fill bank
  assign s_axis_tready = 1'b1;
  assign accept = s_axis_tvalid && s_vid_active && ctrl_en_reg;
  assign wx = s_axis_tuser ? '0 : wr_x_reg;
  assign line_done = accept && (s_axis_tlast || (wx == X_LAST));
  assign take = (state_reg == ST_IDLE) && pend_vld_reg;

  // fill position; a full-length line closes itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_x_reg <= '0;
      wr_bank_reg <= 1'b0;
      line_sof_reg <= 1'b0;
    end else if (line_done) begin
      wr_x_reg <= '0;
      wr_bank_reg <= !wr_bank_reg;
      line_sof_reg <= 1'b0;
    end else if (accept) begin
      wr_x_reg <= wx + 1'b1;
      if (s_axis_tuser) begin
        line_sof_reg <= 1'b1;
      end
    end
  end

  // finished line waits here; a new line beats the hand-off clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_vld_reg <= 1'b0;
      pend_bank_reg <= 1'b0;
      pend_sof_reg <= 1'b0;
      pend_len_reg <= '0;
    end else if (line_done) begin
      pend_vld_reg <= 1'b1;
      pend_bank_reg <= wr_bank_reg;
      pend_sof_reg <= line_sof_reg || s_axis_tuser;
      pend_len_reg <= L_W'(wx) + 1'b1;
    end else if (take) begin
      pend_vld_reg <= 1'b0;
    end
  end

  // ==========================================================
  // output sequencer: vblank on a frame start, line, hblank, same line again, hblank
  assign issue = ((state_reg == ST_LINE_A) || (state_reg == ST_LINE_B)) &&
                 (!out_vld_reg || m_axis_tready);
  assign last_px = (L_W'(rd_x_reg) + 1'b1) == rd_len_reg;
  // a zero setting still gives one blank cycle
  assign blank_len = (state_reg == ST_VBLANK) ?
                     ((vblank_reg == '0) ? BLANK_ONE : vblank_reg) :
                     ((hblank_reg == '0) ? BLANK_ONE : hblank_reg);
  assign blank_end = (blank_cnt_reg + 1'b1) >= blank_len;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          state_next = pend_sof_reg ? ST_VBLANK : ST_LINE_A;
        end
      end
      ST_VBLANK: begin
        if (blank_end) begin
          state_next = ST_LINE_A;
        end
      end
      ST_LINE_A: begin
        if (issue && last_px) begin
          state_next = ST_HBL_A;
        end
      end
      ST_HBL_A: begin
        if (blank_end) begin
          state_next = ST_LINE_B;
        end
      end
      ST_LINE_B: begin
        if (issue && last_px) begin
          state_next = ST_HBL_B;
        end
      end
      ST_HBL_B: begin
        if (blank_end) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer state, read position and blank counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      rd_x_reg <= '0;
      blank_cnt_reg <= '0;
      rd_bank_reg <= 1'b0;
      rd_sof_reg <= 1'b0;
      rd_len_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (take) begin
        rd_bank_reg <= pend_bank_reg;
        rd_sof_reg <= pend_sof_reg;
        rd_len_reg <= pend_len_reg;
      end
      if (state_next != state_reg) begin
        rd_x_reg <= '0;
        blank_cnt_reg <= '0;
      end else if (issue) begin
        rd_x_reg <= rd_x_reg + 1'b1;
      end else begin
        blank_cnt_reg <= blank_cnt_reg + 1'b1;
      end
    end
  end

  // output flags travel one cycle behind the read issue, like the ram data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_vld_reg <= 1'b0;
      out_sb_reg <= '0;
      hblank_out_reg <= 1'b0;
      vblank_out_reg <= 1'b0;
    end else begin
      if (issue) begin
        out_vld_reg <= 1'b1;
        out_sb_reg.sof <= rd_sof_reg && (state_reg == ST_LINE_A) && (rd_x_reg == '0);
        out_sb_reg.eol <= last_px;
      end else if (m_axis_tready) begin
        out_vld_reg <= 1'b0;
        out_sb_reg <= '0; // a one-pixel line must not leave its frame flag standing
      end
      hblank_out_reg <= (state_next == ST_HBL_A) || (state_next == ST_HBL_B);
      vblank_out_reg <= (state_next == ST_VBLANK);
    end
  end

  assign m_axis_tvalid = out_vld_reg;
  assign m_axis_tuser = out_sb_reg.sof;
  assign m_axis_tlast = out_sb_reg.eol;
  assign m_axis_tdata = ram_rdata;
  assign m_hblank = hblank_out_reg;
  assign m_vblank = vblank_out_reg;

  // ==========================================================
  // two-line store; the memory domain reset clears its read register
  ipv_line_ram #(
    .DATA_W(DATA_W),
    .ADDR_W(X_W + 1)
  ) u_line_ram (
    .aclk(aclk),
    .m_axi_aresetn(m_axi_aresetn),
    .we(accept),
    .waddr({wr_bank_reg, wx}),
    .wdata(fmt_mask(fmt_reg, s_axis_tdata)),
    .re(issue),
    .raddr({rd_bank_reg, rd_x_reg}),
    .rdata(ram_rdata)
  );
endmodule : ipv_video_port
`default_nettype wire
